// ---- logic/jps_defines.svh ----
// Constants for the test port with public instructions and security lockout
`ifndef JPS_DEFINES_SVH
`define JPS_DEFINES_SVH

// ============================================================
// Widths
`define JPS_IR_W      5
`define JPS_ID_W      32
`define JPS_BSC_W     8
`define JPS_ADDR_W    8

// ============================================================
// Instruction opcodes
`define JPS_OP_IDCODE  5'h01
`define JPS_OP_SAMPLE  5'h02
`define JPS_OP_EXTEST  5'h03
`define JPS_OP_INTEST  5'h04
`define JPS_OP_CLAMP   5'h06
`define JPS_OP_CORERST 5'h0C
`define JPS_OP_ERASE   5'h0F
`define JPS_OP_NEXUS   5'h10
`define JPS_OP_WORD    5'h11
`define JPS_OP_BLOCK   5'h12
`define JPS_OP_CANCEL  5'h13
`define JPS_OP_MSERV   5'h14
`define JPS_OP_SIZED   5'h15
`define JPS_OP_SYNC    5'h17
`define JPS_OP_HALT    5'h1C
`define JPS_OP_BYPASS  5'h1F

// ============================================================
// Instruction capture patterns and fields
`define JPS_IR_FIXED   2'h1
`define JPS_IR_PUBLIC  5'h01
`define JPS_IRB_BUSY   2
`define JPS_IRB_ERR    3
`define JPS_IRB_PROT   4

// ============================================================
// Identification value fields (values are arbitrary)
`define JPS_ID_VER     4'h1
`define JPS_ID_PART    16'h5A3C
`define JPS_ID_MFR     11'h123
`define JPS_ID_LSB     1'h1

// ============================================================
// Register map
`define JPS_REG_CTRL   8'h00
`define JPS_REG_STAT   8'h04
`define JPS_REG_ID     8'h08
`define JPS_CTRL_PROT  0
`define JPS_STAT_TAP   0
`define JPS_STAT_IR    4
`define JPS_STAT_SEC   9
`define JPS_STAT_LOCK  10

`endif

// ---- logic/jps_pkg.sv ----
// Types for the test port with public instructions and security lockout
package jps_pkg;

  typedef enum logic [3:0] {
    JPS_TLR    = 4'b0000,
    JPS_RTI    = 4'b0001,
    JPS_SELDR  = 4'b0010,
    JPS_CAPDR  = 4'b0011,
    JPS_SHDR   = 4'b0100,
    JPS_EX1DR  = 4'b0101,
    JPS_PAUSDR = 4'b0110,
    JPS_EX2DR  = 4'b0111,
    JPS_UPDDR  = 4'b1000,
    JPS_SELIR  = 4'b1001,
    JPS_CAPIR  = 4'b1010,
    JPS_SHIR   = 4'b1011,
    JPS_EX1IR  = 4'b1100,
    JPS_PAUSIR = 4'b1101,
    JPS_EX2IR  = 4'b1110,
    JPS_UPDIR  = 4'b1111
  } jps_tap_e;

  typedef enum logic [1:0] {
    JPS_DR_BYP = 2'b00,
    JPS_DR_ID  = 2'b01,
    JPS_DR_BSC = 2'b10
  } jps_dr_e;

endpackage

// ---- logic/jps_top.sv ----
// Test access port: public instructions, boundary chain, security lockout
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "jps_defines.svh"

module jps_top
  import jps_pkg::*;
(
  input  wire logic                   pclk,        // System clock
  input  wire logic                   presetn,     // Async reset, low
  input  wire logic                   pclken,      // Clock enable
  input  wire logic                   psel,        // APB select
  input  wire logic                   penable,     // APB enable
  input  wire logic                   pwrite,      // APB write
  input  wire logic [`JPS_ADDR_W-1:0] paddr,       // APB address
  input  wire logic [31:0]            pwdata,      // APB write data
  output logic      [31:0]            prdata,      // APB read data
  output logic                        pready,      // APB ready
  output logic                        pslverr,     // APB error
  input  wire logic                   tck,         // Test clock pin
  input  wire logic                   tms,         // Test mode pin
  input  wire logic                   tdi,         // Test data in pin
  output logic                        tdo,         // Test data out
  output logic                        tdo_oe,      // Test data out enable
  input  wire logic [`JPS_BSC_W-1:0]  pad_in,      // Pin levels
  output logic      [`JPS_BSC_W-1:0]  pad_out,     // Pin drive values
  input  wire logic [`JPS_BSC_W-1:0]  core_out,    // Core logic outputs
  output logic      [`JPS_BSC_W-1:0]  core_in,     // Core logic inputs
  input  wire logic                   fuse_set,    // Security fuse programmed
  input  wire logic                   flash_rst,   // Flash static reset
  input  wire logic                   sab_busy,    // Service bus busy
  input  wire logic                   sab_error,   // Service bus error
  output logic                        access_lock, // Access restricted
  output logic                        erase_req    // Chip erase pulse
);

  // ============================================================
  // Synchronisers for pins
  logic [2:0]            tck_s;
  logic [1:0]            tms_s;
  logic [1:0]            tdi_s;
  logic [`JPS_BSC_W-1:0] pad_s1;
  logic [`JPS_BSC_W-1:0] pad_s2;
  logic                  tck_rise;
  logic                  tck_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tck_s  <= 3'h0;
      tms_s  <= 2'h3;
      tdi_s  <= 2'h0;
      pad_s1 <= '0;
      pad_s2 <= '0;
    end else if (pclken) begin
      tck_s  <= {tck_s[1:0], tck};
      tms_s  <= {tms_s[0], tms};
      tdi_s  <= {tdi_s[0], tdi};
      pad_s1 <= pad_in;
      pad_s2 <= pad_s1;
    end
  end

  // Edges seen one stage late so the data pins are aligned with them
  assign tck_rise = tck_s[1] & ~tck_s[2];
  assign tck_fall = ~tck_s[1] & tck_s[2];

  // ============================================================
  // Controller state machine
  jps_tap_e tap;
  jps_tap_e next_tap;
  logic     m;

  always_comb begin
    m = tms_s[1];
    case (tap)
      JPS_TLR:    next_tap = m ? JPS_TLR   : JPS_RTI;
      JPS_RTI:    next_tap = m ? JPS_SELDR : JPS_RTI;
      JPS_SELDR:  next_tap = m ? JPS_SELIR : JPS_CAPDR;
      JPS_CAPDR:  next_tap = m ? JPS_EX1DR : JPS_SHDR;
      JPS_SHDR:   next_tap = m ? JPS_EX1DR : JPS_SHDR;
      JPS_EX1DR:  next_tap = m ? JPS_UPDDR : JPS_PAUSDR;
      JPS_PAUSDR: next_tap = m ? JPS_EX2DR : JPS_PAUSDR;
      JPS_EX2DR:  next_tap = m ? JPS_UPDDR : JPS_SHDR;
      JPS_UPDDR:  next_tap = m ? JPS_SELDR : JPS_RTI;
      JPS_SELIR:  next_tap = m ? JPS_TLR   : JPS_CAPIR;
      JPS_CAPIR:  next_tap = m ? JPS_EX1IR : JPS_SHIR;
      JPS_SHIR:   next_tap = m ? JPS_EX1IR : JPS_SHIR;
      JPS_EX1IR:  next_tap = m ? JPS_UPDIR : JPS_PAUSIR;
      JPS_PAUSIR: next_tap = m ? JPS_EX2IR : JPS_PAUSIR;
      JPS_EX2IR:  next_tap = m ? JPS_UPDIR : JPS_SHIR;
      JPS_UPDIR:  next_tap = m ? JPS_SELDR : JPS_RTI;
      default:    next_tap = JPS_TLR;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tap <= JPS_TLR;
    end else if (pclken && tck_rise) begin
      tap <= next_tap;
    end
  end

  // ============================================================
  // Instruction register and decode
  logic [`JPS_IR_W-1:0] ir;
  logic [`JPS_IR_W-1:0] ir_sh;
  logic                 priv;
  logic                 secure;
  logic                 prot_en;
  jps_dr_e              dr_sel;
  logic                 drive_bs;

  always_comb begin
    case (ir)
      `JPS_OP_CORERST, `JPS_OP_ERASE, `JPS_OP_NEXUS, `JPS_OP_WORD,
      `JPS_OP_BLOCK, `JPS_OP_CANCEL, `JPS_OP_MSERV, `JPS_OP_SIZED,
      `JPS_OP_SYNC, `JPS_OP_HALT: priv = 1'b1;
      default:                   priv = 1'b0;
    endcase
  end

  // Undefined and private opcodes land on the bypass bit here
  always_comb begin
    case (ir)
      `JPS_OP_IDCODE: dr_sel = JPS_DR_ID;
      `JPS_OP_SAMPLE,
      `JPS_OP_EXTEST,
      `JPS_OP_INTEST: dr_sel = JPS_DR_BSC;
      default:        dr_sel = JPS_DR_BYP;
    endcase
  end

  assign drive_bs = (ir == `JPS_OP_EXTEST) || (ir == `JPS_OP_INTEST) ||
                    (ir == `JPS_OP_CLAMP);
  assign secure   = fuse_set | flash_rst;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir    <= `JPS_OP_IDCODE;
      ir_sh <= `JPS_IR_PUBLIC;
    end else if (pclken && tck_rise) begin
      case (tap)
        JPS_TLR: ir <= `JPS_OP_IDCODE;
        JPS_CAPIR: begin
          if (priv) begin
            // Status pattern: protect, error, busy, then fixed 0 and 1
            ir_sh <= {prot_en & secure, sab_error, sab_busy,
                      `JPS_IR_FIXED};
          end else begin
            ir_sh <= `JPS_IR_PUBLIC;
          end
        end
        JPS_SHIR: ir_sh <= {tdi_s[1], ir_sh[`JPS_IR_W-1:1]};
        JPS_UPDIR: ir <= ir_sh;
        default: ir <= ir;
      endcase
    end
  end

  // ============================================================
  // Data register chains
  logic [`JPS_ID_W-1:0]  dr_sh;
  logic [`JPS_BSC_W-1:0] bs_upd;
  logic [`JPS_ID_W-1:0]  id_val;

  assign id_val = {`JPS_ID_VER, `JPS_ID_PART, `JPS_ID_MFR, `JPS_ID_LSB};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dr_sh <= '0;
    end else if (pclken && tck_rise) begin
      if (tap == JPS_CAPDR) begin
        case (dr_sel)
          JPS_DR_ID:  dr_sh <= id_val;
          JPS_DR_BSC: begin
            if (ir == `JPS_OP_INTEST) begin
              dr_sh[`JPS_BSC_W-1:0] <= core_out;
            end else begin
              dr_sh[`JPS_BSC_W-1:0] <= pad_s2;
            end
          end
          default:    dr_sh[0] <= 1'b0;
        endcase
      end else if (tap == JPS_SHDR) begin
        // Partial scans simply leave the tail bits where they were
        case (dr_sel)
          JPS_DR_ID:  dr_sh <= {tdi_s[1], dr_sh[`JPS_ID_W-1:1]};
          JPS_DR_BSC: dr_sh[`JPS_BSC_W-1:0] <=
                        {tdi_s[1], dr_sh[`JPS_BSC_W-1:1]};
          default:    dr_sh[0] <= tdi_s[1];
        endcase
      end
    end
  end

  // Preload leaves the update latch alone so the pins never glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bs_upd <= '0;
    end else if (pclken && tck_rise && tap == JPS_UPDDR &&
                 (ir == `JPS_OP_EXTEST || ir == `JPS_OP_INTEST)) begin
      bs_upd <= dr_sh[`JPS_BSC_W-1:0];
    end
  end

  // ============================================================
  // Pin and core multiplexing, one cell per bit
  genvar gi;
  generate
    for (gi = 0; gi < `JPS_BSC_W; gi = gi + 1) begin : g_cell
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pad_out[gi] <= 1'b0;
          core_in[gi] <= 1'b0;
        end else if (pclken) begin
          pad_out[gi] <= drive_bs ? bs_upd[gi] : core_out[gi];
          core_in[gi] <= (ir == `JPS_OP_INTEST) ? bs_upd[gi]
                                                : pad_s2[gi];
        end
      end
    end
  endgenerate

  // ============================================================
  // Test data out, changed on falling test clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (pclken && tck_fall) begin
      tdo    <= (tap == JPS_SHIR) ? ir_sh[0] : dr_sh[0];
      tdo_oe <= (tap == JPS_SHIR) || (tap == JPS_SHDR);
    end
  end

  // ============================================================
  // Security lockout and erase request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_lock <= 1'b1;
    end else if (pclken) begin
      // Follows the fuse or flash reset, so erase clearing them reopens access
      access_lock <= secure;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erase_req <= 1'b0;
    end else if (pclken) begin
      erase_req <= tck_rise && tap == JPS_UPDIR &&
                   ir_sh == `JPS_OP_ERASE;
    end
  end

  // ============================================================
  // APB slave, one wait state
  logic acc;
  logic hit;

  assign acc = psel & penable & ~pready;
  assign hit = (paddr == `JPS_REG_CTRL) || (paddr == `JPS_REG_STAT) ||
               (paddr == `JPS_REG_ID);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (pclken) begin
      pready  <= acc;
      pslverr <= acc & ~hit;
      prdata  <= 32'h0;
      if (acc && !pwrite) begin
        case (paddr)
          `JPS_REG_CTRL: prdata[`JPS_CTRL_PROT] <= prot_en;
          `JPS_REG_STAT: begin
            prdata[`JPS_STAT_TAP +: $bits(tap)] <= tap;
            prdata[`JPS_STAT_IR +: `JPS_IR_W]  <= ir;
            prdata[`JPS_STAT_SEC]              <= secure;
            prdata[`JPS_STAT_LOCK]             <= access_lock;
          end
          `JPS_REG_ID:   prdata <= id_val;
          default:       prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_en <= 1'b0;
    end else if (pclken && acc && pwrite && paddr == `JPS_REG_CTRL) begin
      prot_en <= pwdata[`JPS_CTRL_PROT];
    end
  end

  // ============================================================
  // Checks
  a_ir_reset: assert property (@(posedge pclk) disable iff (!presetn)
    (pclken && tck_rise && tap == JPS_TLR) |=> ir == `JPS_OP_IDCODE)
    else $error("instruction not identification after reset state");

  a_lock_set: assert property (@(posedge pclk) disable iff (!presetn)
    (pclken && (fuse_set || flash_rst)) |=> access_lock)
    else $error("access not restricted while secured");

  a_lock_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (presetn && pclken && !fuse_set && !flash_rst) |=> !access_lock)
    else $error("access still restricted after fuse cleared");

  a_byp_capture: assert property (@(posedge pclk) disable iff (!presetn)
    (pclken && tck_rise && tap == JPS_CAPDR && dr_sel == JPS_DR_BYP)
    |=> dr_sh[0] == 1'b0)
    else $error("bypass bit not zero after capture");

  a_id_capture: assert property (@(posedge pclk) disable iff (!presetn)
    (pclken && tck_rise && tap == JPS_CAPDR && dr_sel == JPS_DR_ID)
    |=> dr_sh == id_val)
    else $error("identification value not captured");

  a_id_shift: assert property (@(posedge pclk) disable iff (!presetn)
    (pclken && tck_rise && tap == JPS_SHDR && dr_sel == JPS_DR_ID)
    |=> dr_sh[`JPS_ID_W-2:0] == $past(dr_sh[`JPS_ID_W-1:1]))
    else $error("identification chain not shifted toward bit zero");

  a_ir_status: assert property (@(posedge pclk) disable iff (!presetn)
    (pclken && tck_rise && tap == JPS_CAPIR && priv)
    |=> ir_sh[1:0] == `JPS_IR_FIXED && ir_sh[`JPS_IRB_BUSY] == $past(sab_busy)
        && ir_sh[`JPS_IRB_ERR] == $past(sab_error))
    else $error("private status pattern wrong");

  a_pin_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (pclken && drive_bs) ##1 pclken |-> pad_out == $past(bs_upd))
    else $error("pins not driven from chain latch");

  a_core_feed: assert property (@(posedge pclk) disable iff (!presetn)
    (pclken && ir == `JPS_OP_INTEST) |=> core_in == $past(bs_upd))
    else $error("core inputs not fed from chain latch");

endmodule

// ---- tb/jps_tester.sv ----
// Behavioural test-port tester: drives test clock, mode and data, reads TDO
`timescale 1ns/1ps
module jps_tester (
  input  wire logic pclk,   // System clock
  input  wire logic tdo,    // Test data from device
  input  wire logic tdo_oe, // Test data enable from device
  output logic      tck,    // Test clock, still between frames
  output logic      tms,    // Test mode
  output logic      tdi     // Test data
);
  // Enable seen high on every shifted bit of the last scan
  logic oe;

  initial begin
    oe  = 1'b0;
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // ============================================================
  // One test clock of 8 system clocks: low 5, high 3
  // TDO is taken late in the low phase so the synchroniser has settled
  task automatic tick(input logic m, input logic d, output logic q);
    @(posedge pclk);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge pclk);
    q = tdo;
    tck <= 1'b1;
    repeat (3) @(posedge pclk);
    tck <= 1'b0;
  endtask

  task automatic walk(input logic [7:0] path, input int n);
    logic q;
    for (int i = 0; i < n; i++)
      tick(path[i], 1'b0, q);
  endtask

  // From idle through capture, shift n bits, update, back to idle
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
                      output logic [31:0] dout);
    logic q;
    dout = 32'h0;
    oe = 1'b1;
    walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
      oe = oe & tdo_oe;
    end
    walk(8'h01, 2);
    // Update lands on the last edge; let it reach the pins before callers look
    repeat (2) @(posedge pclk);
  endtask
endmodule

// ---- tb/jps_top_tb.sv ----
// Self-checking bench for the test port with security lockout
`timescale 1ns/1ps
`include "jps_defines.svh"
`define CHK(nm, e, g) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("unexpected %s: expected %h seen %h", nm, (e), (g)); \
  end \
end
module jps_top_tb
  import jps_pkg::*;
;
  localparam logic [31:0] ID_EXP = {`JPS_ID_VER, `JPS_ID_PART,
                                    `JPS_ID_MFR, `JPS_ID_LSB};
  logic        pclk, presetn, pclken, psel, penable, pwrite;
  logic [7:0]  paddr, pad_in, pad_out, core_out, core_in, a, b;
  logic [31:0] pwdata, prdata, rd, din, dout;
  logic        pready, pslverr, tck, tms, tdi, tdo, tdo_oe, err;
  logic        fuse_set, flash_rst, sab_busy, sab_error;
  logic        access_lock, erase_req;
  int          n_errors, n_checks, n_erase;
  int unsigned seed;
  logic [4:0]  ops [5] = '{`JPS_OP_CLAMP, `JPS_OP_NEXUS, 5'h05, 5'h1A,
                           `JPS_OP_BYPASS};

  jps_top u_jps_top (.pclk, .presetn, .pclken, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .tck, .tms, .tdi, .tdo,
    .tdo_oe, .pad_in, .pad_out, .core_out, .core_in, .fuse_set,
    .flash_rst, .sab_busy, .sab_error, .access_lock, .erase_req);
  jps_tester u_jps_tester (.pclk, .tdo, .tdo_oe, .tck, .tms, .tdi);

  always #20 pclk = ~pclk;
  always @(posedge pclk) if (erase_req === 1'b1) n_erase++;

  // ============================================================
  // Expectations and bus helpers
  function automatic logic [7:0] byp(input logic [7:0] d);
    return {d[6:0], 1'b0};
  endfunction
  function automatic logic [4:0] stat(input logic p, e, bz);
    return {p, e, bz, 2'b01};
  endfunction

  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ir(input logic [4:0] op);
    u_jps_tester.scan(1'b1, {27'h0, op}, 5, dout);
  endtask
  task automatic dr(input int n);
    din = $urandom;
    din[0] = 1'b1;
    u_jps_tester.scan(1'b0, din, n, dout);
  endtask

  task automatic lock(input logic f, input logic r, input logic e);
    @(posedge pclk);
    fuse_set <= f;
    flash_rst <= r;
    repeat (4) @(posedge pclk);
    `CHK("access_lock", e, access_lock)
    apb(1'b0, `JPS_REG_STAT, 32'h0);
    `CHK("secure", f | r, rd[9])
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #1000000;
    n_errors++;
    summarize();
  end

  // ============================================================
  // Main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {pad_in, core_out, fuse_set, flash_rst, sab_busy, sab_error} = '0;
    pclken = 1'b1;
    n_errors = 0;
    n_checks = 0;
    n_erase = 0;
    seed = $urandom(23254);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `JPS_REG_STAT, 32'h0);
    `CHK("stat", {2'b00, `JPS_OP_IDCODE, JPS_TLR}, rd[10:0])
    apb(1'b0, `JPS_REG_ID, 32'h0);
    `CHK("id reg", ID_EXP, rd)
    apb(1'b0, 8'h0C, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {err, rd})
    core_out <= 8'($urandom);
    u_jps_tester.walk(8'h1F, 6);
    dr(32);
    `CHK("idcode", ID_EXP, dout)
    `CHK("tdo_oe", 2'b10, {u_jps_tester.oe, tdo_oe})
    ir(`JPS_OP_SAMPLE);
    `CHK("ir public", 5'h01, dout[4:0])
    apb(1'b0, `JPS_REG_STAT, 32'h0);
    `CHK("ir tap", {`JPS_OP_SAMPLE, JPS_RTI}, rd[8:0])
    pad_in <= 8'($urandom);
    dr(8);
    `CHK("sample", pad_in, dout[7:0])
    `CHK("sample pad", core_out, pad_out)
    ir(`JPS_OP_EXTEST);
    pad_in <= 8'($urandom);
    dr(8);
    a = din[7:0];
    `CHK("extest cap", pad_in, dout[7:0])
    `CHK("extest pad", a, pad_out)
    foreach (ops[j]) begin
      ir(ops[j]);
      dr(8);
      `CHK("bypass", byp(din[7:0]), dout[7:0])
      `CHK("pad", ops[j] == `JPS_OP_CLAMP ? a : core_out, pad_out)
    end
    ir(`JPS_OP_EXTEST);
    `CHK("extest load", a, pad_out)
    ir(`JPS_OP_INTEST);
    core_out <= 8'($urandom);
    dr(8);
    b = din[7:0];
    `CHK("intest cap", core_out, dout[7:0])
    `CHK("intest core", b, core_in)
    `CHK("intest pad", b, pad_out)
    // Reset in mid-run must bring back identification and normal pins
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `JPS_REG_STAT, 32'h0);
    `CHK("stat reset", {2'b00, `JPS_OP_IDCODE, JPS_TLR}, rd[10:0])
    `CHK("pad reset", core_out, pad_out)
    u_jps_tester.walk(8'h1F, 6);
    apb(1'b1, `JPS_REG_CTRL, 32'h1);
    apb(1'b0, `JPS_REG_CTRL, 32'h0);
    `CHK("ctrl", 32'h1, rd)
    lock(1'b1, 1'b0, 1'b1);
    lock(1'b0, 1'b1, 1'b1);
    lock(1'b0, 1'b0, 1'b0);
    ir(`JPS_OP_NEXUS);
    for (int k = 0; k < 16; k++) begin
      apb(1'b1, `JPS_REG_CTRL, {31'h0, k[3]});
      @(posedge pclk);
      fuse_set <= k[2];
      sab_error <= k[1];
      sab_busy <= k[0];
      ir(`JPS_OP_NEXUS);
      `CHK("ir status", stat(k[2] & k[3], k[1], k[0]), dout[4:0])
    end
    lock(1'b1, 1'b0, 1'b1);
    ir(`JPS_OP_ERASE);
    `CHK("erase pulses", 1, n_erase)
    lock(1'b0, 1'b0, 1'b0);
    summarize();
  end
endmodule
